// file: common/port_transport_pkg.sv
// Shared constants, types and functions of the switch port transport block
// Operation
// - Check received packet integrity before routing
// - Valid packet indexes table by destination
// - Own 512-entry table, flat or hierarchical
// - Bad CRC: discard, request retransmission
// - Forward the CRC that arrived on non-maintenance packets
// - Keep sent packets until accepted
// - Alter only maintenance packets
// - Hop count zero goes to register bus
// - Build and queue maintenance response
// - Nonzero hop: decrement, recompute CRC, route
// - Bad control symbol: drop, send not-accepted
// - Good control symbols drive transmit, link
// - One maintenance transaction outstanding
// - Register accesses are 32-bit words
// - Eight ingress, eight egress packet buffers
// - Forward multicast-event symbol with low latency
// - Cut-through or store-and-forward selectable
// - Port numbering for 4x or 1x
package port_transport_pkg;
  localparam int RT_ENTRIES = 512;
  localparam int RT_AW = 9;
  localparam int PORTS_1X = 16;
  localparam int PORT_W = 4;
  localparam int BUFS = 8;
  localparam int ACK_W = 3;
  localparam int FIFO_DEPTH = 4;
  localparam int DEST_W = 16;
  localparam int HOP_W = 8;
  localparam int CRC_W = 16;
  localparam int BODY_W = 32;
  localparam logic [CRC_W-1:0] CRC_POLY = 16'h1021;
  localparam logic [CRC_W-1:0] CRC_INIT = 16'hffff;
  localparam logic [HOP_W-1:0] HOP_LOCAL = 8'h00;
  localparam logic [2:0] CS_PA = 3'h0;
  localparam logic [2:0] CS_PR = 3'h1;
  localparam logic [2:0] CS_PNA = 3'h2;
  localparam logic [2:0] CS_LINK = 3'h4;
  localparam logic [2:0] CS_MCE = 3'h5;

  typedef struct packed {
    logic [PORT_W-1:0] port;
    logic mcast;
    logic maint;
    logic cut;
    logic [DEST_W-1:0] dest;
    logic [HOP_W-1:0] hop;
    logic [CRC_W-1:0] crc;
    logic [BODY_W-1:0] body;
  } fwd_s;

  function automatic logic [CRC_W-1:0] crc16(input logic [DEST_W+HOP_W+BODY_W-1:0] d);
    logic [CRC_W-1:0] c;
    c = CRC_INIT;
    for (int i = DEST_W + HOP_W + BODY_W - 1; i >= 0; i--) begin
      c = (c[CRC_W-1] ^ d[i]) ? ({c[CRC_W-2:0], 1'b0} ^ CRC_POLY) : {c[CRC_W-2:0], 1'b0};
    end
    return c;
  endfunction
endpackage

// file: hdl/port_transport.sv
// Transport layer of one serial switch port, with its forwarding FIFO
`timescale 1ns/100ps

module fwd_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != CW'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (clk_en && push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (clk_en) begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
      end
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end
endmodule // fwd_fifo

module port_transport #(
  parameter int BUFS = port_transport_pkg::BUFS,
  parameter int FIFO_DEPTH = port_transport_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic rx_crc_ok,
  input wire logic [2:0] rx_ackid,
  input wire logic rx_maint,
  input wire logic [15:0] rx_dest,
  input wire logic [7:0] rx_hop,
  input wire logic [15:0] rx_crc,
  input wire logic [31:0] rx_body,
  input wire logic cs_valid,
  input wire logic cs_crc_ok,
  input wire logic [2:0] cs_type,
  input wire logic [2:0] cs_param,
  input wire logic rt_wr,
  input wire logic [8:0] rt_idx,
  input wire logic [3:0] rt_port,
  input wire logic rt_mcast,
  input wire logic hier_en,
  input wire logic [7:0] local_domain,
  input wire logic lane_4x,
  input wire logic cut_through,
  output logic fab_valid,
  input wire logic fab_ready,
  input wire logic fab_done,
  output logic [3:0] fab_port,
  output logic fab_mcast,
  output logic fab_maint,
  output logic fab_cut,
  output logic [15:0] fab_dest,
  output logic [7:0] fab_hop,
  output logic [15:0] fab_crc,
  output logic [31:0] fab_body,
  output logic mreq_valid,
  output logic [31:0] mreq_body,
  input wire logic mresp_valid,
  input wire logic [31:0] mresp_body,
  input wire logic eg_valid,
  output logic eg_ready,
  input wire logic [15:0] eg_crc,
  input wire logic [31:0] eg_body,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [2:0] tx_ackid,
  output logic [15:0] tx_crc,
  output logic [31:0] tx_body,
  output logic tx_cs_valid,
  output logic [2:0] tx_cs_type,
  output logic [2:0] tx_cs_param,
  output logic mce_out,
  output logic link_req
);
  localparam int PW = port_transport_pkg::ACK_W + 1;
  localparam int IW = $clog2(BUFS + 1);
  localparam int FW = $bits(port_transport_pkg::fwd_s);

  // ----------------------------------------------------------------
  // Lookup table and receive decode
  // ----------------------------------------------------------------
  logic [4:0] rt_mem [port_transport_pkg::RT_ENTRIES];
  logic [port_transport_pkg::RT_AW-1:0] rt_sel;
  logic [4:0] rt_hit;
  logic [2:0] exp_r;
  logic busy_r;
  logic take;
  logic rx_ok;
  logic is_local;
  logic retry;
  logic issue;
  logic fwd;
  logic [7:0] hop_dec;

  always_ff @(posedge core_clk) begin
    if (clk_en && rt_wr) begin
      rt_mem[rt_idx] <= {rt_mcast, rt_port};
    end
  end

  // Hierarchical mode splits the table: local domain by low byte, else by domain
  always_comb begin
    if (hier_en) begin
      rt_sel = (rx_dest[15:8] == local_domain) ? {1'b0, rx_dest[7:0]} : {1'b1, rx_dest[15:8]};
    end else begin
      rt_sel = rx_dest[8:0];
    end
  end
  assign rt_hit = rt_mem[rt_sel];

  // A packet offered with a control symbol waits, so only one reply goes out
  assign take = rx_valid && rx_ready && !cs_valid;
  assign rx_ok = rx_crc_ok && (rx_ackid == exp_r);
  assign is_local = rx_maint && (rx_hop == port_transport_pkg::HOP_LOCAL);
  assign retry = is_local && busy_r;
  assign issue = take && rx_ok && is_local && !busy_r;
  assign fwd = take && rx_ok && !is_local;
  assign hop_dec = rx_hop - 8'h01;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      exp_r <= '0;
    end else if (clk_en && take && rx_ok && !retry) begin
      exp_r <= exp_r + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Control symbol validation
  // ----------------------------------------------------------------
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] ack_ptr_r;
  logic [PW-1:0] tx_ptr_r;
  logic field_ok;
  logic cs_good;
  logic cs_bad;
  logic pa_hit;
  logic rewind;

  always_comb begin
    unique case (cs_type)
      port_transport_pkg::CS_PA: field_ok = (cs_param == ack_ptr_r[2:0]) && (tx_ptr_r != ack_ptr_r);
      port_transport_pkg::CS_PR,
      port_transport_pkg::CS_PNA,
      port_transport_pkg::CS_LINK,
      port_transport_pkg::CS_MCE: field_ok = 1'b1;
      default: field_ok = 1'b0;
    endcase
  end
  assign cs_good = cs_valid && cs_crc_ok && field_ok;
  assign cs_bad = cs_valid && !(cs_crc_ok && field_ok);
  assign pa_hit = cs_good && (cs_type == port_transport_pkg::CS_PA);
  assign rewind = cs_good && (cs_type == port_transport_pkg::CS_PR || cs_type == port_transport_pkg::CS_PNA);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_cs_valid <= 1'b0;
      tx_cs_type <= port_transport_pkg::CS_PA;
      tx_cs_param <= '0;
    end else if (clk_en) begin
      tx_cs_valid <= cs_bad || take;
      if (cs_bad || (take && !rx_ok)) begin
        tx_cs_type <= port_transport_pkg::CS_PNA;
        tx_cs_param <= exp_r;
      end else if (take && retry) begin
        tx_cs_type <= port_transport_pkg::CS_PR;
        tx_cs_param <= rx_ackid;
      end else if (take) begin
        tx_cs_type <= port_transport_pkg::CS_PA;
        tx_cs_param <= rx_ackid;
      end
    end
  end

  // Multicast events bypass all packet queues
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mce_out <= 1'b0;
      link_req <= 1'b0;
    end else if (clk_en) begin
      mce_out <= cs_good && (cs_type == port_transport_pkg::CS_MCE);
      link_req <= cs_good && (cs_type == port_transport_pkg::CS_LINK);
    end
  end

  // ----------------------------------------------------------------
  // Ingress stage, FIFO and crossbar handoff
  // ----------------------------------------------------------------
  port_transport_pkg::fwd_s stg_r;
  port_transport_pkg::fwd_s fifo_out;
  logic stg_v_r;
  logic stg_v_nxt;
  logic f_in_ready;
  logic f_out_valid;
  logic f_pop;
  logic [IW-1:0] in_cnt_r;
  logic [IW-1:0] in_cnt_nxt;

  assign stg_v_nxt = (stg_v_r && !f_in_ready) || fwd;
  assign in_cnt_nxt = in_cnt_r + IW'(fwd) - IW'(fab_done && in_cnt_r != '0);
  assign f_pop = f_out_valid && (!fab_valid || fab_ready);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stg_v_r <= 1'b0;
      stg_r <= '0;
      in_cnt_r <= '0;
      rx_ready <= 1'b0;
    end else if (clk_en) begin
      stg_v_r <= stg_v_nxt;
      in_cnt_r <= in_cnt_nxt;
      rx_ready <= !stg_v_nxt && (in_cnt_nxt < IW'(BUFS));
      if (fwd) begin
        stg_r.port <= lane_4x ? {rt_hit[3:1], 1'b0} : rt_hit[3:0];
        stg_r.mcast <= rt_hit[4];
        stg_r.maint <= rx_maint;
        stg_r.cut <= cut_through;
        stg_r.dest <= rx_dest;
        stg_r.body <= rx_body;
        stg_r.hop <= rx_maint ? hop_dec : rx_hop;
        stg_r.crc <= rx_maint ? port_transport_pkg::crc16({rx_dest, hop_dec, rx_body}) : rx_crc;
      end
    end
  end

  fwd_fifo #(
    .W(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .in_valid(stg_v_r),
    .in_ready(f_in_ready),
    .in_data(stg_r),
    .out_valid(f_out_valid),
    .out_ready(!fab_valid || fab_ready),
    .out_data(fifo_out)
  );

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fab_valid <= 1'b0;
      {fab_port, fab_mcast, fab_maint, fab_cut, fab_dest, fab_hop, fab_crc, fab_body} <= '0;
    end else if (clk_en) begin
      if (f_pop) begin
        fab_valid <= 1'b1;
        {fab_port, fab_mcast, fab_maint, fab_cut, fab_dest, fab_hop, fab_crc, fab_body} <= fifo_out;
      end else if (fab_ready) begin
        fab_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Local maintenance access
  // ----------------------------------------------------------------
  logic rsp_pend_r;
  logic [31:0] rsp_body_r;
  logic rsp_wr;
  logic eg_wr;
  logic [PW-1:0] eg_cnt;

  assign eg_cnt = wr_ptr_r - ack_ptr_r;
  assign rsp_wr = rsp_pend_r && (eg_cnt < PW'(BUFS));
  assign eg_wr = eg_valid && eg_ready;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mreq_valid <= 1'b0;
      mreq_body <= '0;
      busy_r <= 1'b0;
      rsp_pend_r <= 1'b0;
      rsp_body_r <= '0;
    end else if (clk_en) begin
      mreq_valid <= issue;
      if (issue) begin
        mreq_body <= rx_body;
      end
      // Busy until the reply is queued, so a second request gets a retry
      busy_r <= issue || (busy_r && !rsp_wr);
      rsp_pend_r <= mresp_valid || (rsp_pend_r && !rsp_wr);
      if (mresp_valid) begin
        rsp_body_r <= mresp_body;
      end
    end
  end

  // ----------------------------------------------------------------
  // Egress retention and transmit
  // ----------------------------------------------------------------
  logic [31:0] ret_body [BUFS];
  logic [15:0] ret_crc [BUFS];
  logic [PW-1:0] eg_cnt_nxt;

  assign eg_cnt_nxt = eg_cnt + PW'(rsp_wr || eg_wr) - PW'(pa_hit);

  always_ff @(posedge core_clk) begin
    if (clk_en && (rsp_wr || eg_wr)) begin
      ret_body[wr_ptr_r[2:0]] <= rsp_wr ? rsp_body_r : eg_body;
      ret_crc[wr_ptr_r[2:0]] <= rsp_wr ? port_transport_pkg::crc16({24'h000000, rsp_body_r}) : eg_crc;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      ack_ptr_r <= '0;
      eg_ready <= 1'b0;
    end else if (clk_en) begin
      wr_ptr_r <= wr_ptr_r + PW'(rsp_wr || eg_wr);
      ack_ptr_r <= ack_ptr_r + PW'(pa_hit);
      eg_ready <= !(mresp_valid || (rsp_pend_r && !rsp_wr)) && (eg_cnt_nxt < PW'(BUFS));
    end
  end

  // Rewind abandons the packet in flight; the partner discards it anyway
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ptr_r <= '0;
      tx_valid <= 1'b0;
      tx_ackid <= '0;
      tx_crc <= '0;
      tx_body <= '0;
    end else if (clk_en) begin
      if (rewind) begin
        tx_ptr_r <= ack_ptr_r;
        tx_valid <= 1'b0;
      end else if ((!tx_valid || tx_ready) && tx_ptr_r != wr_ptr_r) begin
        tx_ptr_r <= tx_ptr_r + PW'(1);
        tx_valid <= 1'b1;
        tx_ackid <= tx_ptr_r[2:0];
        tx_crc <= ret_crc[tx_ptr_r[2:0]];
        tx_body <= ret_body[tx_ptr_r[2:0]];
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk iff clk_en); endclocking
  default disable iff (!arst_n);

  crc_fail_pna_a: assert property (take && !rx_crc_ok |=> tx_cs_valid && tx_cs_type == port_transport_pkg::CS_PNA)
    else $error("bad packet not answered with not-accepted");
  bad_no_route_a: assert property (take && !rx_ok |=> !stg_v_r || $past(stg_v_r))
    else $error("failed packet entered the forwarding path");
  hop0_request_a: assert property (issue |=> mreq_valid && mreq_body == $past(rx_body))
    else $error("local maintenance request not issued");
  one_outstanding_a: assert property (busy_r && take && rx_ok && is_local |=> !mreq_valid
    && tx_cs_type == port_transport_pkg::CS_PR)
    else $error("second maintenance request not retried");
  hop_decrement_a: assert property (fwd && rx_maint |=> stg_r.hop == $past(rx_hop) - 8'h01)
    else $error("hop count not decremented");
  crc_kept_a: assert property (fwd && !rx_maint |=> stg_r.crc == $past(rx_crc) && stg_r.body == $past(rx_body))
    else $error("non-maintenance packet altered");
  cs_reject_a: assert property (cs_valid && !cs_crc_ok |=> tx_cs_valid && tx_cs_type == port_transport_pkg::CS_PNA
    && !mce_out && !link_req)
    else $error("bad control symbol not rejected");
  mce_fast_a: assert property (cs_valid && cs_crc_ok && cs_type == port_transport_pkg::CS_MCE |=> mce_out)
    else $error("multicast event not forwarded next cycle");
  retain_full_a: assert property (eg_cnt == PW'(BUFS) |-> !eg_ready && !rsp_wr)
    else $error("egress retention overrun");
  rsp_queued_a: assert property (mresp_valid && eg_cnt == '0 |=> ##[0:1] wr_ptr_r != $past(wr_ptr_r, 2))
    else $error("maintenance response not queued");
  in_limit_a: assert property (in_cnt_r >= IW'(BUFS) |-> !rx_ready)
    else $error("ingress buffers overcommitted");

  fwd_pkt_c: cover property (fwd ##[1:8] fab_valid && fab_ready);
  local_maint_c: cover property (issue ##[1:20] rsp_wr);
  rewind_c: cover property (tx_valid && tx_ready ##[1:10] rewind);
  mce_c: cover property (mce_out);
endmodule // port_transport

// file: sim/link_partner.sv
// Behavioural far end of the serial link for the port transport bench
`timescale 1ns/100ps

module link_partner (
  input wire logic core_clk,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic rx_crc_ok,
  output logic [2:0] rx_ackid,
  output logic rx_maint,
  output logic [15:0] rx_dest,
  output logic [7:0] rx_hop,
  output logic [15:0] rx_crc,
  output logic [31:0] rx_body,
  output logic cs_valid,
  output logic cs_crc_ok,
  output logic [2:0] cs_type,
  output logic [2:0] cs_param,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [2:0] tx_ackid,
  input wire logic [15:0] tx_crc,
  input wire logic [31:0] tx_body,
  input wire logic tx_cs_valid,
  input wire logic [2:0] tx_cs_type,
  input wire logic [2:0] tx_cs_param
);
  logic [2:0] next_id = 3'h0;
  logic [56:0] held;
  logic tx_stall = 1'b0;
  int got_n = 0;
  logic [2:0] got_ackid;
  logic [15:0] got_crc;
  logic [31:0] got_body;

  initial begin
    {rx_valid, rx_crc_ok, rx_ackid, rx_maint, rx_dest, rx_hop, rx_crc, rx_body} = '0;
    {cs_valid, cs_crc_ok, cs_type, cs_param, tx_ready} = '0;
  end

  // ----------------------------------------
  // Words from the port
  // ----------------------------------------
  // Stalls come from the bench so slow acceptance is tested on demand
  always @(negedge core_clk) begin
    tx_ready <= !tx_stall;
  end

  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) begin
      got_ackid <= tx_ackid;
      got_crc <= tx_crc;
      got_body <= tx_body;
      got_n <= got_n + 1;
    end
  end

  function automatic logic [15:0] crc_of(input logic [55:0] d);
    logic [15:0] c;
    c = port_transport_pkg::CRC_INIT;
    for (int i = 55; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? port_transport_pkg::CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // ----------------------------------------
  // Packets and symbols to the port
  // ----------------------------------------
  // Idle data lines show inverted data; rx_crc_ok, rx_ackid and rx_maint keep their last value
  task automatic send(input logic mt, input logic [15:0] dst, input logic [7:0] hp, input logic good,
                      input logic [31:0] bd, output logic ok, output logic [2:0] id,
                      output logic [2:0] st, output logic [2:0] sp);
    int n;
    n = 0;
    id = next_id;
    held = {mt, dst, hp, bd};
    @(negedge core_clk);
    {rx_valid, rx_crc_ok, rx_ackid, rx_maint} = {1'b1, good, id, mt};
    {rx_dest, rx_hop, rx_crc, rx_body} = {dst, hp, crc_of({dst, hp, bd}), bd};
    while (!rx_ready && n < 12) begin
      @(negedge core_clk);
      n++;
    end
    ok = rx_ready;
    if (ok) begin
      @(negedge core_clk);
    end
    // Reply stands one cycle only, so read it right after the take
    st = tx_cs_valid ? tx_cs_type : 3'h7;
    sp = tx_cs_param;
    rx_valid = 1'b0;
    {rx_dest, rx_hop, rx_crc, rx_body} = ~{rx_dest, rx_hop, rx_crc, rx_body};
    if (st == 3'h0 && sp == id) begin
      next_id++;
    end
  endtask

  task automatic resend(output logic ok, output logic [2:0] id, output logic [2:0] st, output logic [2:0] sp);
    send(held[56], held[55:40], held[39:32], 1'b1, held[31:0], ok, id, st, sp);
  endtask

  task automatic sym(input logic good, input logic [2:0] t, input logic [2:0] p, output logic [2:0] st,
                     output logic [2:0] sp);
    @(negedge core_clk);
    {cs_valid, cs_crc_ok, cs_type, cs_param} = {1'b1, good, t, p};
    @(negedge core_clk);
    st = tx_cs_valid ? tx_cs_type : 3'h7;
    sp = tx_cs_param;
    cs_valid = 1'b0;
    {cs_type, cs_param} = ~{cs_type, cs_param};
  endtask
endmodule // link_partner

// file: sim/serial_switch_port_transport_tb.sv
// Self-checking bench of the switch port transport block
`timescale 1ns/100ps

module serial_switch_port_transport_tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en, rx_valid, rx_ready, rx_crc_ok, rx_maint, cs_valid, cs_crc_ok, rt_wr, rt_mcast, hier_en;
  logic lane_4x, cut_through, fab_valid, fab_ready, fab_done, fab_mcast, fab_maint, fab_cut, mreq_valid;
  logic mresp_valid, eg_valid, eg_ready, tx_valid, tx_ready, tx_cs_valid, mce_out, link_req;
  logic [2:0] rx_ackid, cs_type, cs_param, tx_ackid, tx_cs_type, tx_cs_param, id, st, sp;
  logic [3:0] rt_port, fab_port;
  logic [7:0] rx_hop, local_domain, fab_hop;
  logic [8:0] rt_idx;
  logic [15:0] rx_dest, rx_crc, fab_dest, fab_crc, eg_crc, tx_crc;
  logic [31:0] rx_body, fab_body, mreq_body, mresp_body, eg_body, tx_body;
  logic ok;
  logic [2:0] tx_id = 3'h0;
  int miscompares = 0;
  int n_checks = 0;

  always #12.5 core_clk = ~core_clk;

  port_transport u_dut (.*);
  link_partner u_far (.*);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic stuck(input string what);
    miscompares++;
    $display("[ERR] %s expected handshake seen none", what);
    wrap_up();
  endtask

  task automatic rt_set(input logic [8:0] i, input logic [3:0] p);
    @(negedge core_clk);
    {rt_wr, rt_idx, rt_port, rt_mcast} = {1'b1, i, p, p[0]};
    @(negedge core_clk);
    rt_wr = 1'b0;
  endtask

  task automatic take_fab(output port_transport_pkg::fwd_s f);
    // One edge between calls, so fab_ready never falls and rises in one step
    @(negedge core_clk);
    for (int n = 0; n < 20 && fab_valid !== 1'b1; n++) @(negedge core_clk);
    if (fab_valid !== 1'b1) stuck("fab_valid");
    f = {fab_port, fab_mcast, fab_maint, fab_cut, fab_dest, fab_hop, fab_crc, fab_body};
    fab_ready = 1'b1;
    @(negedge core_clk);
    fab_ready = 1'b0;
  endtask

  task automatic release_buf;
    @(negedge core_clk);
    fab_done = 1'b1;
    @(negedge core_clk);
    fab_done = 1'b0;
  endtask

  task automatic wait_tx(input int seen);
    for (int n = 0; n < 30 && u_far.got_n <= seen; n++) @(negedge core_clk);
    if (u_far.got_n <= seen) stuck("tx_word");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Row: mode {hier, 4x, cut, maint}, dest, table index, table port, expected port
  task automatic route_cases;
    logic [39:0] rows [4] = '{40'h0_0105_105_55, 40'ha_1234_034_99, 40'h9_5607_156_33, 40'h5_0042_042_76};
    port_transport_pkg::fwd_s f;
    logic [7:0] hp;
    local_domain = 8'h12;
    foreach (rows[k]) begin
      {hier_en, lane_4x, cut_through} = rows[k][39:37];
      rt_set(rows[k][16:8], rows[k][7:4]);
      hp = rows[k][36] ? 8'h02 : 8'h03;
      u_far.send(rows[k][36], rows[k][35:20], 8'h03, 1'b1, {16'h5a00, rows[k][35:20]}, ok, id, st, sp);
      check("rx_pa", {st, sp}, {3'h0, id});
      take_fab(f);
      check("fab_port", {f.port, f.mcast}, rows[k][3:0] * 2 + rows[k][4]);
      check("fab_tags", {f.cut, f.maint, f.dest}, {rows[k][37:36], rows[k][35:20]});
      check("fab_hop", f.hop, hp);
      check("fab_crc", f.crc, u_far.crc_of({rows[k][35:20], hp, 16'h5a00, rows[k][35:20]}));
      check("fab_body", f.body, {16'h5a00, rows[k][35:20]});
      release_buf;
    end
    {hier_en, lane_4x, cut_through} = 3'h0;
  endtask

  task automatic bad_packet;
    port_transport_pkg::fwd_s f;
    u_far.send(1'b0, 16'h0105, 8'h01, 1'b0, 32'h0000_dead, ok, id, st, sp);
    check("bad_pna", {st, sp}, {3'h2, id});
    repeat (3) @(negedge core_clk);
    check("no_fwd", fab_valid, 1'b0);
    u_far.resend(ok, id, st, sp);
    check("resend_pa", {st, sp}, {3'h0, id});
    take_fab(f);
    check("fwd_body", f.body, 32'h0000_dead);
    release_buf;
  endtask

  task automatic egress;
    int seen;
    seen = u_far.got_n;
    u_far.tx_stall = 1'b1;
    @(negedge core_clk);
    {eg_valid, eg_crc, eg_body} = {1'b1, 16'h3c5a, 32'h0bad_f00d};
    for (int n = 0; n < 12 && eg_ready !== 1'b1; n++) @(negedge core_clk);
    if (eg_ready !== 1'b1) stuck("eg_ready");
    @(negedge core_clk);
    {eg_valid, eg_crc, eg_body} = {1'b0, 16'hc3a5, 32'hf452_0ff2};
    repeat (4) @(negedge core_clk);
    check("tx_hold", {tx_valid, tx_crc}, {1'b1, 16'h3c5a});
    u_far.tx_stall = 1'b0;
    wait_tx(seen);
    check("tx_word", {u_far.got_ackid, u_far.got_crc}, {tx_id, 16'h3c5a});
    check("tx_body", u_far.got_body, 32'h0bad_f00d);
    u_far.sym(1'b1, 3'h2, tx_id, st, sp);
    wait_tx(seen + 1);
    check("resent", {u_far.got_ackid, u_far.got_crc}, {tx_id, 16'h3c5a});
    u_far.sym(1'b1, 3'h0, tx_id, st, sp);
    check("pa_quiet", st, 3'h7);
    tx_id++;
  endtask

  task automatic respond(input logic [31:0] b);
    int seen;
    seen = u_far.got_n;
    @(negedge core_clk);
    {mresp_valid, mresp_body} = {1'b1, b};
    @(negedge core_clk);
    {mresp_valid, mresp_body} = {1'b0, ~b};
    wait_tx(seen);
    check("resp_body", u_far.got_body, b);
    check("resp_crc", u_far.got_crc, u_far.crc_of({24'h000000, b}));
    check("resp_ackid", u_far.got_ackid, tx_id);
    u_far.sym(1'b1, 3'h0, tx_id, st, sp);
    tx_id++;
  endtask

  task automatic local_maint;
    u_far.send(1'b1, 16'h0000, 8'h00, 1'b1, 32'h1234_5678, ok, id, st, sp);
    check("mreq_pa", {st, mreq_valid}, {3'h0, 1'b1});
    check("mreq_body", mreq_body, 32'h1234_5678);
    u_far.send(1'b1, 16'h0000, 8'h00, 1'b1, 32'h9abc_def0, ok, id, st, sp);
    check("busy_pr", {st, sp, mreq_valid}, {3'h1, id, 1'b0});
    respond(32'hcafe_0042);
    u_far.send(1'b1, 16'h0000, 8'h00, 1'b1, 32'h9abc_def0, ok, id, st, sp);
    check("after_resp", {st, mreq_valid}, {3'h0, 1'b1});
    respond(32'h0000_7e57);
  endtask

  // Row: good, type, param, expected reply, multicast event, link request
  task automatic symbols;
    logic [11:0] rows [5] = '{12'h408, 12'hf08, 12'h8a8, 12'hd1e, 12'hc1d};
    foreach (rows[k]) begin
      u_far.sym(rows[k][11], rows[k][10:8], rows[k][7:5], st, sp);
      check("cs_reply", st, rows[k][4:2]);
      if (rows[k][4:2] == 3'h2) check("pna_param", sp, u_far.next_id);
      check("mce_link", {mce_out, link_req}, rows[k][1:0]);
    end
  endtask

  // Clock enable low must keep every reply and pulse still
  task automatic freeze;
    @(negedge core_clk);
    clk_en = 1'b0;
    u_far.sym(1'b0, 3'h0, 3'h0, st, sp);
    check("frozen_cs", st, 3'h7);
    u_far.sym(1'b1, 3'h5, 3'h0, st, sp);
    check("frozen_mce", mce_out, 1'b0);
    clk_en = 1'b1;
  endtask

  // Crossbar stalls first, so the queue must refuse before all buffers are used
  task automatic buffers;
    port_transport_pkg::fwd_s f;
    int n;
    n = 0;
    ok = 1'b1;
    while (ok && n < 8) begin
      u_far.send(1'b0, 16'h0105, 8'h01, 1'b1, 32'(n), ok, id, st, sp);
      n += int'(ok);
    end
    check("fifo_full", n >= port_transport_pkg::FIFO_DEPTH && n < 8, 1'b1);
    for (int i = 0; i < 8; i++) begin
      if (i >= n) u_far.send(1'b0, 16'h0105, 8'h01, 1'b1, 32'(i), ok, id, st, sp);
      take_fab(f);
      check("fifo_order", f.body, 32'(i));
    end
    u_far.send(1'b0, 16'h0105, 8'h01, 1'b1, 32'h0000_0008, ok, id, st, sp);
    check("ninth_refused", ok, 1'b0);
    repeat (8) release_buf;
    u_far.send(1'b0, 16'h0105, 8'h01, 1'b1, 32'h0000_0008, ok, id, st, sp);
    check("ninth_taken", ok, 1'b1);
    take_fab(f);
    release_buf;
  endtask

  initial begin
    {clk_en, rt_wr, rt_mcast, hier_en, lane_4x, cut_through, fab_ready, fab_done, mresp_valid, eg_valid} = 10'h200;
    {rt_idx, rt_port, local_domain, mresp_body, eg_crc, eg_body} = '0;
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    route_cases();
    bad_packet();
    egress();
    local_maint();
    symbols();
    freeze();
    buffers();
    wrap_up();
  end

  initial begin
    #2000000;
    stuck("run_time");
  end
endmodule // serial_switch_port_transport_tb
